// ---- npic_params.svh ----
`ifndef NPIC_PARAMS_SVH
`define NPIC_PARAMS_SVH
// ****************************************
// Register indices (byte address = index * 4)
// ****************************************
`define NPIC_IDX_EOI 8'h22
`define NPIC_IDX_POLL 8'h24
`define NPIC_IDX_POLLSTS 8'h26
`define NPIC_IDX_MASK 8'h28
`define NPIC_IDX_PRIMSK 8'h2a
`define NPIC_IDX_INSERV 8'h2c
`define NPIC_IDX_REQ 8'h2e
`define NPIC_IDX_TMRCTL 8'h32
`define NPIC_IDX_DMA0CTL 8'h34
`define NPIC_IDX_DMA1CTL 8'h36
`define NPIC_IDX_EXTA 8'h38
`define NPIC_IDX_EXTB 8'h3a
`define NPIC_IDX_EXTC 8'h3c
`define NPIC_IDX_EXTD 8'h3e
// ****************************************
// Field positions and reset values
// ****************************************
`define NPIC_PR_MSB 2
`define NPIC_MSK_BIT 3
`define NPIC_LTM_BIT 4
`define NPIC_CASC_BIT 5
`define NPIC_SPECIAL_NESTED_SELECT_BIT 6
`define NPIC_POLL_REQ_BIT 15
`define NPIC_EOI_NSPEC_BIT 15
`define NPIC_VEC_MSB 4
`define NPIC_SRC_VALID 8'hfd
`define NPIC_PR_DEFAULT 3'h7
`define NPIC_PRIMSK_RESET 3'h7
`define NPIC_MASK_RESET 8'hfd
`define NPIC_ACK2_LEN 2'h3
`define NPIC_RESP_OKAY 2'h0
`define NPIC_RESP_SLVERR 2'h2
// Vector types per source bit
`define NPIC_VEC_TMR 5'h08
`define NPIC_VEC_D0 5'h0a
`define NPIC_VEC_D1 5'h0b
`define NPIC_VEC_EXTA 5'h0c
`define NPIC_VEC_EXTB 5'h0d
`define NPIC_VEC_EXTC 5'h0e
`define NPIC_VEC_EXTD 5'h0f
`endif

// ---- npic_pkg.sv ----
package npic_pkg;
  // ****************************************
  // Types
  // ****************************************
  typedef enum logic [3:0] {
    S_IDLE = 4'b0001,
    S_ACK1 = 4'b0010,
    S_GAP = 4'b0100,
    S_ACK2 = 4'b1000
  } npic_state_t;

  // Per-source control bits (mask bit lives in the mask register)
  typedef struct packed {
    logic special_nested_select;
    logic casc;
    logic level_trigger_select;
    logic [2:0] pr;
  } npic_ctl_t;

  typedef struct packed {
    npic_state_t st;
    logic [1:0] cnt;
    logic sel_b;
    logic [7:0] req;
    logic [7:0] inserv;
    logic [7:0] mask;
    logic [2:0] primsk;
    npic_ctl_t [7:0] ctl;
    logic [3:0] pin_s1;
    logic [3:0] pin_s2;
    logic [3:0] pin_d;
    logic nmi_s1;
    logic nmi_s2;
    logic nmi_d;
    logic nmi_out;
    logic [7:0] vec_s1;
    logic [7:0] vec_s2;
    logic [7:0] vector;
    logic vec_valid;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } npic_regs_t;
endpackage : npic_pkg

// ---- npic_top.sv ----
`timescale 1ns/10ps
`include "npic_params.svh"
// Notes on behaviour
// - Five external inputs, one non-maskable
// - Four pins: direct, one pair, two pairs
// - Cascade ack: two cycles, vector second
// - Internal sources same in every mode
// - Lower priority blocked by in-service
// - Same source blocked while in service
// - Pin c acks a, pin d acks b
// - Each pair cascaded via own control
// - Special nested: own pin re-requests allowed
// - Special nested still sets, blocks lower
// - Poll: bit 15 pending, 4-0 type
// - Poll read sets in-service like acknowledge
// - Poll status read changes nothing
// - Three-bit level, smaller wins, defaulted
// - Ties broken by fixed source order
// - Non-specific end clears highest in-service
// - Specific end clears named source only
// - Edge: re-armed after one low cycle
// - Level: requests while input high
// - Trigger bit: one level, zero edge
// - Cascade bit: one cascade, zero direct
// - In-service set on ack or poll
module npic_top
  import npic_pkg::*;
(
  input wire logic MCLK,
  input wire logic RST_N,
  input wire logic [11:0] S_AXI_AWADDR,
  input wire logic S_AXI_AWVALID,
  output logic S_AXI_AWREADY,
  input wire logic [31:0] S_AXI_WDATA,
  input wire logic [3:0] S_AXI_WSTRB,
  input wire logic S_AXI_WVALID,
  output logic S_AXI_WREADY,
  output logic [1:0] S_AXI_BRESP,
  output logic S_AXI_BVALID,
  input wire logic S_AXI_BREADY,
  input wire logic [11:0] S_AXI_ARADDR,
  input wire logic S_AXI_ARVALID,
  output logic S_AXI_ARREADY,
  output logic [31:0] S_AXI_RDATA,
  output logic [1:0] S_AXI_RRESP,
  output logic S_AXI_RVALID,
  input wire logic S_AXI_RREADY,
  input wire logic NMI_REQUEST,
  input wire logic EXT_REQUEST_A,
  input wire logic EXT_REQUEST_B,
  input wire logic EXT_REQUEST_C_OR_ACK_A_IN,
  output logic EXT_REQUEST_C_OR_ACK_A_OUT,
  output logic EXT_REQUEST_C_OR_ACK_A_OE,
  input wire logic EXT_REQUEST_D_OR_ACK_B_IN,
  output logic EXT_REQUEST_D_OR_ACK_B_OUT,
  output logic EXT_REQUEST_D_OR_ACK_B_OE,
  input wire logic [7:0] CASC_VECTOR,
  input wire logic TIMER_REQUEST,
  input wire logic [1:0] DMA_REQUEST,
  input wire logic CPU_ACK,
  output logic CPU_INT_REQ,
  output logic [7:0] CPU_VECTOR,
  output logic CPU_VECTOR_VALID,
  output logic NMI_OUT
);
  // ****************************************
  // Declarations
  // ****************************************
  npic_regs_t r_ff;
  npic_regs_t nxt_r;
  logic [7:0] src_ok;
  logic [7:0] live;
  logic [7:0] eff;
  logic found;
  logic [2:0] win;
  logic [2:0] bpr;
  logic blocked;
  logic isv_found;
  logic [2:0] isv_idx;
  logic [2:0] isv_pr;
  logic wr_fire;
  logic rd_fire;
  logic [7:0] widx;
  logic [7:0] ridx;
  logic wr_hit;
  logic rd_hit;
  logic [31:0] rd_word;
  logic grant;
  logic ack_take;
  logic poll_take;
  logic win_casc;
  logic ack_on;

  // Fixed vector type of each source bit
  function automatic logic [4:0] vec_of(input logic [2:0] idx);
    case (idx)
      3'h0: vec_of = `NPIC_VEC_TMR;
      3'h2: vec_of = `NPIC_VEC_D0;
      3'h3: vec_of = `NPIC_VEC_D1;
      3'h4: vec_of = `NPIC_VEC_EXTA;
      3'h5: vec_of = `NPIC_VEC_EXTB;
      3'h6: vec_of = `NPIC_VEC_EXTC;
      3'h7: vec_of = `NPIC_VEC_EXTD;
      default: vec_of = 5'h00;
    endcase
  endfunction : vec_of

  // Control word index to source bit; the timer word sits where bit 1 would
  function automatic logic [2:0] src_of(input logic [7:0] idx);
    src_of = (idx[3:1] == 3'h1) ? 3'h0 : idx[3:1];
  endfunction : src_of

  // ****************************************
  // Request qualification
  // ****************************************
  // pins c and d drop out as sources once their pair is cascaded
  assign src_ok = `NPIC_SRC_VALID & ~{r_ff.ctl[5].casc, r_ff.ctl[4].casc, 6'h00};

  for (genvar g = 0; g < 8; g++)
  begin : g_src
    if (g >= 4)
    begin : g_ext
      // level mode follows the synchronised pin directly
      assign live[g] = r_ff.ctl[g].level_trigger_select ? r_ff.pin_s2[g-4] : r_ff.req[g];
    end
    else
    begin : g_int
      // internal sources never depend on the pin mode
      assign live[g] = r_ff.req[g];
    end
    // own in-service blocks, except special nested external pair
    // special nested lets the pin request again
    assign eff[g] = src_ok[g] & live[g] & ~r_ff.mask[g] & (r_ff.ctl[g].pr <= r_ff.primsk) &
                    (~r_ff.inserv[g] | ((g == 4 || g == 5) & r_ff.ctl[g].special_nested_select));
  end

  // ****************************************
  // Arbitration
  // ****************************************
  // Downward scan with <= keeps the lowest index on equal levels
  always_comb
  begin
    found = 1'b0;
    win = 3'h0;
    bpr = 3'h7;
    isv_found = 1'b0;
    isv_idx = 3'h0;
    isv_pr = 3'h7;
    blocked = 1'b0;
    // lowest level wins, ties by fixed order
    for (int i = 7; i >= 0; i--)
    begin
      if (eff[i] && (!found || r_ff.ctl[i].pr <= bpr))
      begin
        found = 1'b1;
        win = 3'(i);
        bpr = r_ff.ctl[i].pr;
      end
      if (r_ff.inserv[i] && (!isv_found || r_ff.ctl[i].pr <= isv_pr))
      begin
        isv_found = 1'b1;
        isv_idx = 3'(i);
        isv_pr = r_ff.ctl[i].pr;
      end
    end
    // any other in-service source ranking above blocks; equal levels block only from a lower index
    for (int j = 0; j < 8; j++)
    begin
      if (r_ff.inserv[j] && 3'(j) != win &&
          (r_ff.ctl[j].pr < bpr || (r_ff.ctl[j].pr == bpr && 3'(j) < win)))
      begin
        blocked = 1'b1;
      end
    end
  end

  assign grant = found & ~blocked;
  assign win_casc = (win == 3'h4 && r_ff.ctl[4].casc) || (win == 3'h5 && r_ff.ctl[5].casc);
  assign CPU_INT_REQ = grant & (r_ff.st == S_IDLE);
  // Acks arriving mid-fetch or with nothing granted are ignored
  assign ack_take = CPU_ACK & CPU_INT_REQ;

  // ****************************************
  // AXI4-Lite decode
  // ****************************************
  // Address and data are taken together; one response outstanding
  assign S_AXI_AWREADY = S_AXI_AWVALID & S_AXI_WVALID & ~r_ff.bvalid;
  assign S_AXI_WREADY = S_AXI_AWREADY;
  assign S_AXI_ARREADY = ~r_ff.rvalid;
  assign wr_fire = S_AXI_AWREADY;
  assign rd_fire = S_AXI_ARVALID & S_AXI_ARREADY;
  assign widx = S_AXI_AWADDR[9:2];
  assign ridx = S_AXI_ARADDR[9:2];
  assign wr_hit = (S_AXI_AWADDR[11:10] == 2'h0) && (S_AXI_AWADDR[1:0] == 2'h0) &&
                  ((widx == `NPIC_IDX_EOI) || (widx >= `NPIC_IDX_MASK && widx <= `NPIC_IDX_REQ) ||
                   (widx >= `NPIC_IDX_TMRCTL && widx <= `NPIC_IDX_EXTD && !widx[0]));
  assign rd_hit = (S_AXI_ARADDR[11:10] == 2'h0) && (S_AXI_ARADDR[1:0] == 2'h0) &&
                  (ridx >= `NPIC_IDX_POLL && ridx <= `NPIC_IDX_EXTD && !ridx[0] &&
                   ridx != 8'h30);
  assign poll_take = rd_fire & rd_hit & (ridx == `NPIC_IDX_POLL) & grant & ~ack_take &
                     (r_ff.st == S_IDLE);

  // Read data mux
  always_comb
  begin
    rd_word = 32'h0;
    case (ridx)
      // both poll words carry the same content
      `NPIC_IDX_POLL, `NPIC_IDX_POLLSTS:
      begin
        rd_word[`NPIC_POLL_REQ_BIT] = grant;
        rd_word[`NPIC_VEC_MSB:0] = vec_of(win);
      end
      `NPIC_IDX_MASK: rd_word[7:0] = r_ff.mask;
      `NPIC_IDX_PRIMSK: rd_word[`NPIC_PR_MSB:0] = r_ff.primsk;
      `NPIC_IDX_INSERV: rd_word[7:0] = r_ff.inserv;
      `NPIC_IDX_REQ: rd_word[7:0] = live & src_ok;
      `NPIC_IDX_TMRCTL, `NPIC_IDX_DMA0CTL, `NPIC_IDX_DMA1CTL, `NPIC_IDX_EXTA,
      `NPIC_IDX_EXTB, `NPIC_IDX_EXTC, `NPIC_IDX_EXTD:
      begin
        rd_word[`NPIC_SPECIAL_NESTED_SELECT_BIT:`NPIC_MSK_BIT] = {r_ff.ctl[src_of(ridx)].special_nested_select,
          r_ff.ctl[src_of(ridx)].casc, r_ff.ctl[src_of(ridx)].level_trigger_select,
          r_ff.mask[src_of(ridx)]};
        rd_word[`NPIC_PR_MSB:0] = r_ff.ctl[src_of(ridx)].pr;
      end
      default: rd_word = 32'h0;
    endcase
  end

  // ****************************************
  // Next state
  // ****************************************
  always_comb
  begin
    nxt_r = r_ff;
    nxt_r.vec_valid = 1'b0;
    // Two-stage synchronisers for every pin
    nxt_r.pin_s1 = {EXT_REQUEST_D_OR_ACK_B_IN, EXT_REQUEST_C_OR_ACK_A_IN, EXT_REQUEST_B,
                    EXT_REQUEST_A};
    nxt_r.pin_s2 = r_ff.pin_s1;
    nxt_r.pin_d = r_ff.pin_s2;
    nxt_r.nmi_s1 = NMI_REQUEST;
    nxt_r.nmi_s2 = r_ff.nmi_s1;
    nxt_r.nmi_d = r_ff.nmi_s2;
    nxt_r.vec_s1 = CASC_VECTOR;
    nxt_r.vec_s2 = r_ff.vec_s1;
    // non-maskable pin bypasses masks and arbitration
    nxt_r.nmi_out = r_ff.nmi_s2 & ~r_ff.nmi_d;

    // Write channel and register updates
    if (wr_fire)
    begin
      nxt_r.bvalid = 1'b1;
      nxt_r.bresp = wr_hit ? `NPIC_RESP_OKAY : `NPIC_RESP_SLVERR;
      if (wr_hit && |S_AXI_WSTRB)
      begin
        case (widx)
          `NPIC_IDX_EOI:
          begin
            if (S_AXI_WDATA[`NPIC_EOI_NSPEC_BIT])
            begin
              if (isv_found)
              begin
                nxt_r.inserv[isv_idx] = 1'b0;
              end
            end
            else
            begin
              // clear only the source with the given type
              for (int i = 0; i < 8; i++)
              begin
                if (vec_of(3'(i)) == S_AXI_WDATA[`NPIC_VEC_MSB:0])
                begin
                  nxt_r.inserv[i] = 1'b0;
                end
              end
            end
          end
          `NPIC_IDX_MASK: nxt_r.mask = S_AXI_WDATA[7:0] & `NPIC_SRC_VALID;
          `NPIC_IDX_PRIMSK: nxt_r.primsk = S_AXI_WDATA[`NPIC_PR_MSB:0];
          `NPIC_IDX_INSERV: nxt_r.inserv = S_AXI_WDATA[7:0] & `NPIC_SRC_VALID;
          `NPIC_IDX_REQ: nxt_r.req[3:2] = S_AXI_WDATA[3:2];
          default:
          begin
            nxt_r.mask[src_of(widx)] = S_AXI_WDATA[`NPIC_MSK_BIT];
            nxt_r.ctl[src_of(widx)].pr = S_AXI_WDATA[`NPIC_PR_MSB:0];
            nxt_r.ctl[src_of(widx)].level_trigger_select = S_AXI_WDATA[`NPIC_LTM_BIT];
            // cascade and special nested only on pins a and b
            if (widx == `NPIC_IDX_EXTA || widx == `NPIC_IDX_EXTB)
            begin
              nxt_r.ctl[src_of(widx)].casc = S_AXI_WDATA[`NPIC_CASC_BIT];
              nxt_r.ctl[src_of(widx)].special_nested_select = S_AXI_WDATA[`NPIC_SPECIAL_NESTED_SELECT_BIT];
            end
          end
        endcase
      end
    end
    else if (S_AXI_BREADY)
    begin
      nxt_r.bvalid = 1'b0;
    end

    // Read channel
    if (rd_fire)
    begin
      nxt_r.rvalid = 1'b1;
      nxt_r.rdata = rd_hit ? rd_word : 32'h0;
      nxt_r.rresp = rd_hit ? `NPIC_RESP_OKAY : `NPIC_RESP_SLVERR;
    end
    else if (S_AXI_RREADY)
    begin
      nxt_r.rvalid = 1'b0;
    end

    // acknowledge or poll marks winner in service
    if (ack_take || poll_take)
    begin
      nxt_r.req[win] = 1'b0;
      nxt_r.inserv[win] = 1'b1;
    end
    if (ack_take)
    begin
      if (win_casc)
      begin
        nxt_r.st = S_ACK1;
        nxt_r.sel_b = win[0];
        nxt_r.cnt = 2'h0;
      end
      else
      begin
        nxt_r.vector = {3'h0, vec_of(win)};
        nxt_r.vec_valid = 1'b1;
      end
    end

    // two acknowledge cycles, vector taken in the second
    case (r_ff.st)
      S_IDLE: nxt_r.cnt = 2'h0;
      S_ACK1: nxt_r.st = S_GAP;
      S_GAP: nxt_r.st = S_ACK2;
      S_ACK2:
      begin
        // Held long enough for the vector to clear the synchroniser
        nxt_r.cnt = r_ff.cnt + 2'h1;
        if (r_ff.cnt == `NPIC_ACK2_LEN - 2'h1)
        begin
          nxt_r.vector = r_ff.vec_s2;
          nxt_r.vec_valid = 1'b1;
          nxt_r.st = S_IDLE;
        end
      end
      default: nxt_r.st = S_IDLE;
    endcase

    // Hardware sets last so they win over any clear
    // edge pending only on a low-to-high step
    for (int k = 0; k < 4; k++)
    begin
      if (r_ff.pin_s2[k] && !r_ff.pin_d[k])
      begin
        nxt_r.req[4+k] = 1'b1;
      end
    end
    if (TIMER_REQUEST)
    begin
      nxt_r.req[0] = 1'b1;
    end
    for (int k = 0; k < 2; k++)
    begin
      if (DMA_REQUEST[k])
      begin
        nxt_r.req[2+k] = 1'b1;
      end
    end
  end

  // ****************************************
  // State register
  // ****************************************
  always_ff @(posedge MCLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      r_ff <= '0;
      r_ff.st <= S_IDLE;
      r_ff.mask <= `NPIC_MASK_RESET;
      r_ff.primsk <= `NPIC_PRIMSK_RESET;
      // every source starts at the default level
      for (int i = 0; i < 8; i++)
      begin
        r_ff.ctl[i].pr <= `NPIC_PR_DEFAULT;
      end
    end
    else
    begin
      r_ff <= nxt_r;
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  // pins c and d become acknowledge outputs of their pair
  assign ack_on = (r_ff.st == S_ACK1) || (r_ff.st == S_ACK2);
  assign EXT_REQUEST_C_OR_ACK_A_OE = r_ff.ctl[4].casc;
  assign EXT_REQUEST_D_OR_ACK_B_OE = r_ff.ctl[5].casc;
  assign EXT_REQUEST_C_OR_ACK_A_OUT = ack_on & ~r_ff.sel_b;
  assign EXT_REQUEST_D_OR_ACK_B_OUT = ack_on & r_ff.sel_b;
  assign S_AXI_BVALID = r_ff.bvalid;
  assign S_AXI_BRESP = r_ff.bresp;
  assign S_AXI_RVALID = r_ff.rvalid;
  assign S_AXI_RDATA = r_ff.rdata;
  assign S_AXI_RRESP = r_ff.rresp;
  assign CPU_VECTOR = r_ff.vector;
  assign CPU_VECTOR_VALID = r_ff.vec_valid;
  assign NMI_OUT = r_ff.nmi_out;

  // ****************************************
  // Assertions
  // ****************************************
  property p_nmi_pass;
    @(posedge MCLK) disable iff (!RST_N) r_ff.nmi_s2 && !r_ff.nmi_d |=> NMI_OUT ##1 !NMI_OUT;
  endproperty
  a_nmi_pass: assert property (p_nmi_pass) else $error("nmi not passed");

  property p_casc_seq;
    @(posedge MCLK) disable iff (!RST_N)
      ack_take && win_casc |=> ack_on ##1 !ack_on ##1 ack_on [*3] ##1 CPU_VECTOR_VALID;
  endproperty
  a_casc_seq: assert property (p_casc_seq) else $error("cascade fetch wrong");

  property p_casc_vec;
    @(posedge MCLK) disable iff (!RST_N)
      r_ff.st == S_ACK2 && r_ff.cnt == `NPIC_ACK2_LEN - 2'h1 |=> CPU_VECTOR == $past(r_ff.vec_s2);
  endproperty
  a_casc_vec: assert property (p_casc_vec) else $error("vector not from bus");

  property p_ack_pin;
    @(posedge MCLK) disable iff (!RST_N)
      EXT_REQUEST_C_OR_ACK_A_OUT |-> EXT_REQUEST_C_OR_ACK_A_OE && !r_ff.sel_b;
  endproperty
  a_ack_pin: assert property (p_ack_pin) else $error("ack pin a misdriven");

  property p_nested;
    @(posedge MCLK) disable iff (!RST_N)
      CPU_INT_REQ |-> r_ff.ctl[win].pr <= r_ff.primsk &&
        !(r_ff.inserv[win] && !r_ff.ctl[win].special_nested_select) && (!isv_found || isv_pr >= bpr);
  endproperty
  a_nested: assert property (p_nested) else $error("blocked request raised");

  property p_poll_set;
    @(posedge MCLK) disable iff (!RST_N) poll_take |=> r_ff.inserv[$past(win)] && S_AXI_RVALID;
  endproperty
  a_poll_set: assert property (p_poll_set) else $error("poll left flag clear");

  property p_pollsts_keep;
    @(posedge MCLK) disable iff (!RST_N)
      rd_fire && ridx == `NPIC_IDX_POLLSTS && !wr_fire && !ack_take |=> $stable(r_ff.inserv);
  endproperty
  a_pollsts_keep: assert property (p_pollsts_keep) else $error("status read changed flags");

  property p_eoi_ns;
    @(posedge MCLK) disable iff (!RST_N)
      wr_fire && wr_hit && widx == `NPIC_IDX_EOI && S_AXI_WDATA[`NPIC_EOI_NSPEC_BIT] &&
      isv_found && !ack_take && !poll_take |=> !r_ff.inserv[$past(isv_idx)];
  endproperty
  a_eoi_ns: assert property (p_eoi_ns) else $error("eoi left flag set");

  property p_edge_hold;
    @(posedge MCLK) disable iff (!RST_N)
      !r_ff.req[4] && r_ff.pin_d[0] && r_ff.pin_s2[0] |=> !r_ff.req[4];
  endproperty
  a_edge_hold: assert property (p_edge_hold) else $error("edge re-armed while high");

  property p_level;
    @(posedge MCLK) disable iff (!RST_N)
      r_ff.ctl[4].level_trigger_select && r_ff.pin_s2[0] && !r_ff.mask[4] && !r_ff.inserv[4] &&
      r_ff.ctl[4].pr <= r_ff.primsk |-> found;
  endproperty
  a_level: assert property (p_level) else $error("level input ignored");

  c_casc: cover property (@(posedge MCLK) disable iff (!RST_N) ack_take && win_casc);
  c_poll: cover property (@(posedge MCLK) disable iff (!RST_N) poll_take);
  c_direct: cover property (@(posedge MCLK) disable iff (!RST_N) ack_take && !win_casc);
endmodule : npic_top

// ---- npic_src_model.sv ----
`timescale 1ns/10ps
// ****************
// Far side: sources and cascaded controllers
// ****************
module npic_src_model
  import npic_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [3:0] want,
  input wire logic [7:0] vec_a,
  input wire logic [7:0] vec_b,
  input wire logic ack_a,
  input wire logic oe_a,
  input wire logic ack_b,
  input wire logic oe_b,
  output logic [3:0] pin,
  output logic [7:0] bus
);
  logic [1:0] prev_ff;
  logic [1:0] second_ff;
  logic [7:0] junk_ff;
  assign pin = {oe_b ? ack_b : want[3], oe_a ? ack_a : want[2], want[1:0]};
  // Phase flips on each ack fall; junk stops a stale bus looking valid
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      prev_ff <= 2'h0;
      second_ff <= 2'h0;
      junk_ff <= 8'h5a;
    end
    else
    begin
      prev_ff <= {ack_b & oe_b, ack_a & oe_a};
      second_ff <= second_ff ^ (prev_ff & ~{ack_b & oe_b, ack_a & oe_a});
      junk_ff <= junk_ff + 8'h35;
    end
  end
  assign bus = (oe_a && ack_a && second_ff[0]) ? vec_a :
               (oe_b && ack_b && second_ff[1]) ? vec_b : junk_ff;
endmodule : npic_src_model

// ---- tb.sv ----
`timescale 1ns/10ps
`include "npic_params.svh"
module tb;
  logic MCLK = 1'b0, RST_N = 1'b0, CPU_ACK = 1'b0, NMI_REQUEST = 1'b0, TIMER_REQUEST = 1'b0;
  logic [1:0] DMA_REQUEST = 2'h0, S_AXI_BRESP, S_AXI_RRESP;
  logic [11:0] S_AXI_AWADDR = 12'h0, S_AXI_ARADDR = 12'h0;
  logic [31:0] S_AXI_WDATA = 32'h0, S_AXI_RDATA, rnd, lvl_a;
  logic S_AXI_AWVALID = 1'b0, S_AXI_WVALID = 1'b0, S_AXI_BREADY = 1'b0;
  logic S_AXI_ARVALID = 1'b0, S_AXI_RREADY = 1'b0, ack_q = 1'b0;
  logic S_AXI_AWREADY, S_AXI_WREADY, S_AXI_BVALID, S_AXI_ARREADY, S_AXI_RVALID;
  logic EXT_REQUEST_C_OR_ACK_A_OUT, EXT_REQUEST_C_OR_ACK_A_OE, CPU_INT_REQ;
  logic EXT_REQUEST_D_OR_ACK_B_OUT, EXT_REQUEST_D_OR_ACK_B_OE, CPU_VECTOR_VALID, NMI_OUT;
  logic [7:0] CPU_VECTOR, CASC_VECTOR, vec_a = 8'h0, vec_b = 8'h0;
  logic [3:0] want = 4'h0, pin;
  logic [31:0] qb[$], qr[$], qm[$], qv[$];
  int fails = 0, checks = 0, acks = 0, nmi_n = 0, cyc = 0;
  // ****************
  // Design and far side
  // ****************
  npic_top dut (
    .MCLK, .RST_N, .S_AXI_AWADDR, .S_AXI_AWVALID, .S_AXI_AWREADY, .S_AXI_WDATA,
    .S_AXI_WSTRB(4'hf), .S_AXI_WVALID, .S_AXI_WREADY, .S_AXI_BRESP, .S_AXI_BVALID,
    .S_AXI_BREADY, .S_AXI_ARADDR, .S_AXI_ARVALID, .S_AXI_ARREADY, .S_AXI_RDATA,
    .S_AXI_RRESP, .S_AXI_RVALID, .S_AXI_RREADY, .NMI_REQUEST,
    .EXT_REQUEST_A(pin[0]), .EXT_REQUEST_B(pin[1]), .EXT_REQUEST_C_OR_ACK_A_IN(pin[2]),
    .EXT_REQUEST_C_OR_ACK_A_OUT, .EXT_REQUEST_C_OR_ACK_A_OE,
    .EXT_REQUEST_D_OR_ACK_B_IN(pin[3]), .EXT_REQUEST_D_OR_ACK_B_OUT,
    .EXT_REQUEST_D_OR_ACK_B_OE, .CASC_VECTOR, .TIMER_REQUEST, .DMA_REQUEST,
    .CPU_ACK, .CPU_INT_REQ, .CPU_VECTOR, .CPU_VECTOR_VALID, .NMI_OUT
  );
  npic_src_model partner (
    .clk(MCLK), .rst_n(RST_N), .want(want), .vec_a(vec_a), .vec_b(vec_b),
    .ack_a(EXT_REQUEST_C_OR_ACK_A_OUT), .oe_a(EXT_REQUEST_C_OR_ACK_A_OE),
    .ack_b(EXT_REQUEST_D_OR_ACK_B_OUT), .oe_b(EXT_REQUEST_D_OR_ACK_B_OE),
    .pin(pin), .bus(CASC_VECTOR)
  );
  always #5 MCLK = ~MCLK;
  // ****************
  // Checking
  // ****************
  task automatic chk(input logic [31:0] e, input logic [31:0] g);
    checks++;
    if (g !== e)
    begin
      fails++;
      $display("MISMATCH t=%0t exp=%h got=%h", $time, e, g);
    end
  endtask : chk
  task report_and_stop;
    $display("checks=%0d fails=%0d", checks, fails);
    if (fails == 0 && checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : report_and_stop
  // Result watcher: oldest note against each answer; hang guard
  always @(posedge MCLK)
  begin
    if (S_AXI_BVALID && S_AXI_BREADY)
      chk(qb.pop_front(), {30'h0, S_AXI_BRESP});
    if (S_AXI_RVALID && S_AXI_RREADY)
    begin
      chk(qb.pop_front(), {30'h0, S_AXI_RRESP});
      chk(qr.pop_front(), S_AXI_RDATA & qm.pop_front());
    end
    if (CPU_VECTOR_VALID)
      chk(qv.pop_front(), {24'h0, CPU_VECTOR});
    if (NMI_OUT)
      nmi_n++;
    if (EXT_REQUEST_C_OR_ACK_A_OUT && EXT_REQUEST_C_OR_ACK_A_OE && !ack_q)
      acks++;
    ack_q = EXT_REQUEST_C_OR_ACK_A_OUT;
    cyc++;
    if (cyc == 6000)
    begin
      fails++;
      report_and_stop();
    end
  end
  // ****************
  // Drivers
  // ****************
  task automatic wr(input logic [7:0] i, input logic [31:0] d, input logic [1:0] r = 2'h0);
    qb.push_back({30'h0, r});
    S_AXI_AWADDR <= {2'h0, i, 2'h0};
    S_AXI_WDATA <= d;
    S_AXI_AWVALID <= 1'b1;
    S_AXI_WVALID <= 1'b1;
    S_AXI_BREADY <= 1'b1;
    @(posedge MCLK iff S_AXI_AWREADY);
    S_AXI_AWVALID <= 1'b0;
    S_AXI_WVALID <= 1'b0;
    @(posedge MCLK iff S_AXI_BVALID);
    S_AXI_BREADY <= 1'b0;
    @(posedge MCLK);
  endtask : wr
  task automatic rd(input logic [7:0] i, input logic [31:0] e, input logic [1:0] r = 2'h0,
                    input logic [31:0] m = 32'hffffffff);
    qb.push_back({30'h0, r});
    qr.push_back(e & m);
    qm.push_back(m);
    S_AXI_ARADDR <= {2'h0, i, 2'h0};
    S_AXI_ARVALID <= 1'b1;
    S_AXI_RREADY <= 1'b1;
    @(posedge MCLK iff S_AXI_ARREADY);
    S_AXI_ARVALID <= 1'b0;
    @(posedge MCLK iff S_AXI_RVALID);
    S_AXI_RREADY <= 1'b0;
    @(posedge MCLK);
  endtask : rd
  // Acknowledge once the request shows, then wait for the vector
  task automatic ack(input logic [7:0] v);
    qv.push_back({24'h0, v});
    @(posedge MCLK iff CPU_INT_REQ);
    CPU_ACK <= 1'b1;
    @(posedge MCLK);
    CPU_ACK <= 1'b0;
    while (qv.size() != 0)
      @(posedge MCLK);
  endtask : ack
  // Pin sync plus edge stage settle within six cycles
  task automatic lvl(input logic e);
    repeat (6) @(posedge MCLK);
    chk({31'h0, e}, {31'h0, CPU_INT_REQ});
  endtask : lvl
  // ****************
  // Tests
  // ****************
  initial
  begin
    rnd = $urandom(32'hd21e74e5);
    vec_a = rnd[7:0];
    vec_b = rnd[15:8];
    lvl_a = {30'h0, rnd[17:16]};
    repeat (12) @(posedge MCLK);
    RST_N <= 1'b1;
    @(posedge MCLK);
    rd(`NPIC_IDX_MASK, 32'hfd);
    rd(`NPIC_IDX_PRIMSK, 32'h7);
    rd(`NPIC_IDX_TMRCTL, 32'hf);
    rd(`NPIC_IDX_EXTA, 32'hf);
    rd(8'h30, 32'h0, 2'h2);
    wr(8'h30, 32'h0, 2'h2);
    $display("done: reset");
    wr(`NPIC_IDX_TMRCTL, 32'h5);
    wr(`NPIC_IDX_DMA0CTL, 32'h5);
    wr(`NPIC_IDX_DMA1CTL, 32'h2);
    TIMER_REQUEST <= 1'b1;
    DMA_REQUEST <= 2'h1;
    @(posedge MCLK);
    TIMER_REQUEST <= 1'b0;
    DMA_REQUEST <= 2'h0;
    ack(8'h08);
    lvl(1'b0);
    rd(`NPIC_IDX_INSERV, 32'h1);
    wr(`NPIC_IDX_EOI, 32'h8000);
    ack(8'h0a);
    DMA_REQUEST <= 2'h2;
    @(posedge MCLK);
    DMA_REQUEST <= 2'h0;
    ack(8'h0b);
    wr(`NPIC_IDX_EOI, 32'h8000);
    rd(`NPIC_IDX_INSERV, 32'h4);
    wr(`NPIC_IDX_EOI, 32'ha);
    TIMER_REQUEST <= 1'b1;
    @(posedge MCLK);
    TIMER_REQUEST <= 1'b0;
    rd(`NPIC_IDX_POLLSTS, 32'h8008, 2'h0, 32'h801f);
    rd(`NPIC_IDX_INSERV, 32'h0);
    rd(`NPIC_IDX_POLL, 32'h8008, 2'h0, 32'h801f);
    rd(`NPIC_IDX_INSERV, 32'h1);
    wr(`NPIC_IDX_EOI, 32'h8000);
    $display("done: internal");
    wr(`NPIC_IDX_EXTB, 32'h1);
    want[1] <= 1'b1;
    ack(8'h0d);
    wr(`NPIC_IDX_EOI, 32'hd);
    lvl(1'b0);
    want[1] <= 1'b0;
    @(posedge MCLK);
    want[1] <= 1'b1;
    ack(8'h0d);
    wr(`NPIC_IDX_EXTB, 32'h11);
    lvl(1'b0);
    wr(`NPIC_IDX_EOI, 32'hd);
    ack(8'h0d);
    want[1] <= 1'b0;
    repeat (4) @(posedge MCLK);
    wr(`NPIC_IDX_EOI, 32'hd);
    $display("done: trigger");
    wr(`NPIC_IDX_EXTA, 32'h20 + lvl_a);
    rd(`NPIC_IDX_EXTA, 32'h20 + lvl_a);
    chk(32'h1, {31'h0, EXT_REQUEST_C_OR_ACK_A_OE});
    chk(32'h0, {31'h0, EXT_REQUEST_D_OR_ACK_B_OE});
    want[0] <= 1'b1;
    ack(vec_a);
    chk(32'h2, acks);
    wr(`NPIC_IDX_EXTA, 32'h70 + lvl_a);
    ack(vec_a);
    rd(`NPIC_IDX_INSERV, 32'h10);
    want[0] <= 1'b0;
    repeat (4) @(posedge MCLK);
    wr(`NPIC_IDX_EOI, 32'hc);
    wr(`NPIC_IDX_EXTD, 32'h0);
    want[3] <= 1'b1;
    ack(8'h0f);
    want[3] <= 1'b0;
    wr(`NPIC_IDX_EOI, 32'hf);
    TIMER_REQUEST <= 1'b1;
    @(posedge MCLK);
    TIMER_REQUEST <= 1'b0;
    ack(8'h08);
    wr(`NPIC_IDX_EOI, 32'h8000);
    NMI_REQUEST <= 1'b1;
    repeat (4) @(posedge MCLK);
    NMI_REQUEST <= 1'b0;
    lvl(1'b0);
    chk(32'h1, nmi_n);
    $display("done: cascade");
    report_and_stop();
  end
endmodule : tb
